/* File: rtl/dlp_core.sv */
// Two-channel element-synchronised sequencer with linked parameter reload
//
// What the document requires
// [RULE1] Serial receive uses channel 13, transmit channel 12; one element per event; with the options frame-sync bit set the code moves a whole frame per event.
// [RULE2] Each serial receive or transmit event moves exactly one element; with the options frame-sync bit set the code moves a whole frame per event.
// [RULE3] Destination mode 11b advances address by element and frame index.
// [RULE4] Software sets element and frame index for interleaved two-channel buffers.
// [RULE5] Element size 00b selects 32-bit elements.
// [RULE6] Link set and counts exhausted: copy linked set into channel set, continue.
// [RULE7] Linking to a duplicate of itself runs forever until the CPU halts it.
// [RULE8] Frame sync 0: element count reloads whenever it reaches zero.
// [RULE9] Transmit advances source by index values, destination stays at transmit register.
// [RULE10] Software links ping to pong and back, with identical options and counts.
// [RULE11] On completion the channel loads the linked set and continues alone.
// [RULE12] Completion interrupt enable set: completion raises an interrupt by report code.
// [RULE13] Completion sets the pending bit selected by the report code.
// [RULE14] Pending bits stay set until the CPU clears them.
// [RULE15] CPU polls pending bits or takes the interrupt before touching buffers.
// [RULE16] Linking to an all-zero set stops the channel after its last transfer.
// [RULE17] Address mode 00b holds the address, 01b adds one element.
// [RULE18] Indexed mode adds element index, or frame index after a frame's last element.
// [RULE19] Receive and transmit channels keep counts, addresses and reloads independently.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
module dlp_core (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	input  wire logic        serial_rx_event_i,
	input  wire logic        serial_tx_event_i,
	input  wire logic [8:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	output logic             xfer_valid_o,
	output logic      [3:0]  xfer_chan_o,
	output logic      [31:0] xfer_src_o,
	output logic      [31:0] xfer_dst_o,
	output logic      [2:0]  xfer_bytes_o,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [31:0] parameter_store_r [0:dlp_pkg::PS_WORDS-1];
	logic [1:0]  evt_pend_r;
	logic [1:0]  en_r;
	logic        rr_r;
	logic [15:0] completion_pending_reg_r;
	logic [15:0] cier_r;
	logic        irq_r;
	logic [31:0] rdata_r;
	logic        xv_r;
	logic [3:0]  xchan_r;
	logic [31:0] xsrc_r;
	logic [31:0] xdst_r;
	logic [2:0]  xbytes_r;
	// Per-channel views of the live set and its next value
	logic [31:0] opt_w  [0:1];
	logic [31:0] src_w  [0:1];
	logic [31:0] cnt_w  [0:1];
	logic [31:0] dst_w  [0:1];
	logic [31:0] idx_w  [0:1];
	logic [31:0] rld_w  [0:1];
	logic [31:0] lopt_w [0:1];
	logic [31:0] nxt_w  [0:1][0:5];
	logic [2:0]  sz_w   [0:1];
	logic [1:0]  evt_w;
	logic [1:0]  fire_w;
	logic [1:0]  svc_w;
	logic [1:0]  le_w;
	logic [1:0]  done_w;
	logic [15:0] pend_set;
	logic [15:0] pend_clr;
	assign evt_w = {serial_rx_event_i, serial_tx_event_i};
	// Index-aware address step; indexes are signed 16-bit byte offsets
	function automatic logic [31:0] addr_upd(input logic [31:0] a,
	                                         input logic [1:0]  m,
	                                         input logic [2:0]  sz,
	                                         input logic [15:0] ei,
	                                         input logic [15:0] fi,
	                                         input logic        fe);
		logic [31:0] step;
		step = {29'h0, sz};
		unique case (m)
			dlp_pkg::UPD_FIXED: addr_upd = a;
			dlp_pkg::UPD_INC:   addr_upd = a + step;
			dlp_pkg::UPD_DEC:   addr_upd = a - step;
			dlp_pkg::UPD_IDX:   addr_upd = fe ? a + {{16{fi[15]}}, fi} : a + {{16{ei[15]}}, ei};
		endcase
	endfunction : addr_upd

	////////////////////////////////////////////////////////////////////////////////
	// Channel sequencing, one independent copy per channel
	genvar gc;
	generate
		for (gc = 0; gc < dlp_pkg::CH_NUM; gc++) begin : g_ch // RULE19
			localparam int B = gc * dlp_pkg::SET_WORDS;
			logic [2:0]  lnk;
			logic [1:0]  esz;
			logic [15:0] ecnt;
			logic [15:0] fcnt;
			assign opt_w[gc]  = parameter_store_r[B + dlp_pkg::W_OPT];
			assign src_w[gc]  = parameter_store_r[B + dlp_pkg::W_SRC];
			assign cnt_w[gc]  = parameter_store_r[B + dlp_pkg::W_CNT];
			assign dst_w[gc]  = parameter_store_r[B + dlp_pkg::W_DST];
			assign idx_w[gc]  = parameter_store_r[B + dlp_pkg::W_IDX];
			assign rld_w[gc]  = parameter_store_r[B + dlp_pkg::W_RLD];
			assign lnk        = rld_w[gc][2:0];
			assign lopt_w[gc] = parameter_store_r[int'(lnk) * dlp_pkg::SET_WORDS + dlp_pkg::W_OPT];
			assign esz        = opt_w[gc][dlp_pkg::ELEMENT_SIZE_FIELD_LSB +: 2];
			assign ecnt       = cnt_w[gc][15:0];
			assign fcnt       = cnt_w[gc][31:16];
			// A cleared options word marks a null set that ignores events
			assign fire_w[gc] = evt_pend_r[gc] && en_r[gc] && (opt_w[gc] != 32'h0);
			assign le_w[gc]   = (ecnt <= 16'h1);
			assign done_w[gc] = le_w[gc] && (fcnt == 16'h0);
			always_comb begin
				unique case (esz)
					dlp_pkg::ESZ_32: sz_w[gc] = dlp_pkg::BYTES_32; // RULE5
					dlp_pkg::ESZ_16: sz_w[gc] = dlp_pkg::BYTES_16;
					dlp_pkg::ESZ_8:  sz_w[gc] = dlp_pkg::BYTES_8;
					default:         sz_w[gc] = dlp_pkg::BYTES_32;
				endcase
			end

			always_comb begin
				for (int j = 0; j < dlp_pkg::SET_WORDS; j++) begin
					nxt_w[gc][j] = dlp_pkg::PS_RST;
				end
				if (done_w[gc]) begin
					// Last element of last frame: reload from linked set or go null
					if (opt_w[gc][dlp_pkg::LINK_BIT]) begin // RULE6 RULE7 RULE11 RULE16
						for (int j = 0; j < dlp_pkg::SET_WORDS; j++) begin
							nxt_w[gc][j] = parameter_store_r[int'(lnk) * dlp_pkg::SET_WORDS + j];
						end
					end
				end else begin
					nxt_w[gc][dlp_pkg::W_OPT] = opt_w[gc];
					// Source and destination follow their own update modes
					nxt_w[gc][dlp_pkg::W_SRC] = addr_upd(src_w[gc], // RULE9
						opt_w[gc][dlp_pkg::SUM_LSB +: 2], sz_w[gc],
						idx_w[gc][15:0], idx_w[gc][31:16], le_w[gc]);
					nxt_w[gc][dlp_pkg::W_DST] = addr_upd(dst_w[gc], // RULE3 RULE17 RULE18
						opt_w[gc][dlp_pkg::DUM_LSB +: 2], sz_w[gc],
						idx_w[gc][15:0], idx_w[gc][31:16], le_w[gc]);
					if (le_w[gc]) begin
						nxt_w[gc][dlp_pkg::W_CNT] = {fcnt - 16'h1, rld_w[gc][31:16]}; // RULE8
					end else begin
						nxt_w[gc][dlp_pkg::W_CNT] = {fcnt, ecnt - 16'h1};
					end
					nxt_w[gc][dlp_pkg::W_IDX] = idx_w[gc];
					nxt_w[gc][dlp_pkg::W_RLD] = rld_w[gc];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration: one element request per cycle, alternating on contention
	assign svc_w[0] = fire_w[0] && (!fire_w[1] || rr_r);
	assign svc_w[1] = fire_w[1] && (!fire_w[0] || !rr_r);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rr_r <= 1'b0;
		end else if (ce_i && (fire_w == 2'h3)) begin
			rr_r <= !rr_r;
		end
	end

	// Each event latches a request; a new event wins over its own service clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			evt_pend_r <= 2'h0;
		end else if (ce_i) begin
			for (int c = 0; c < dlp_pkg::CH_NUM; c++) begin
				if (evt_w[c]) begin
					evt_pend_r[c] <= 1'b1; // RULE2
				end else if (svc_w[c] && (!opt_w[c][dlp_pkg::FS_BIT] || le_w[c])) begin
					evt_pend_r[c] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Parameter store: software writes, channel updates take precedence
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int k = 0; k < dlp_pkg::PS_WORDS; k++) begin
				parameter_store_r[k] <= dlp_pkg::PS_RST;
			end
		end else if (ce_i) begin
			if (reg_wr_i && (reg_addr_i < dlp_pkg::OFS_PS_END)) begin
				parameter_store_r[reg_addr_i[7:2]] <= reg_wdata_i;
			end
			for (int c = 0; c < dlp_pkg::CH_NUM; c++) begin
				if (svc_w[c]) begin
					for (int j = 0; j < dlp_pkg::SET_WORDS; j++) begin
						parameter_store_r[c * dlp_pkg::SET_WORDS + j] <= nxt_w[c][j];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Element transfer request
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xv_r     <= 1'b0;
			xchan_r  <= 4'h0;
			xsrc_r   <= 32'h0;
			xdst_r   <= 32'h0;
			xbytes_r <= 3'h0;
		end else if (ce_i) begin
			xv_r <= |svc_w; // RULE2
			if (svc_w[1]) begin
				xchan_r  <= dlp_pkg::RX_CHAN_ID; // RULE1
				xsrc_r   <= src_w[1];
				xdst_r   <= dst_w[1];
				xbytes_r <= sz_w[1];
			end else if (svc_w[0]) begin
				xchan_r  <= dlp_pkg::TX_CHAN_ID; // RULE1
				xsrc_r   <= src_w[0];
				xdst_r   <= dst_w[0];
				xbytes_r <= sz_w[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Completion pending, interrupt enables and channel enables
	always_comb begin
		pend_set = 16'h0;
		for (int c = 0; c < dlp_pkg::CH_NUM; c++) begin
			if (svc_w[c] && done_w[c] && opt_w[c][dlp_pkg::COMPLETION_IRQ_ENABLE_BIT]) begin
				pend_set[opt_w[c][dlp_pkg::TCC_LSB +: 4]] = 1'b1; // RULE13
			end
		end
		pend_clr = (reg_wr_i && (reg_addr_i == dlp_pkg::OFS_COMPLETION_PENDING_REG)) ? reg_wdata_i[15:0] : 16'h0;
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			completion_pending_reg_r <= dlp_pkg::COMPLETION_PENDING_REG_RST;
		end else if (ce_i) begin
			completion_pending_reg_r <= (completion_pending_reg_r & ~pend_clr) | pend_set; // RULE14
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cier_r <= dlp_pkg::CIER_RST;
			en_r   <= dlp_pkg::EER_RST;
		end else if (ce_i && reg_wr_i) begin
			if (reg_addr_i == dlp_pkg::OFS_CIER) begin
				cier_r <= reg_wdata_i[15:0];
			end
			if (reg_addr_i == dlp_pkg::OFS_EER) begin
				en_r <= reg_wdata_i[1:0]; // RULE7
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_r <= 1'b0;
		end else if (ce_i) begin
			irq_r <= |(completion_pending_reg_r & cier_r); // RULE12
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read port
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r <= 32'h0;
		end else if (ce_i) begin
			rdata_r <= 32'h0;
			if (reg_rd_i) begin
				if (reg_addr_i < dlp_pkg::OFS_PS_END) begin
					rdata_r <= parameter_store_r[reg_addr_i[7:2]];
				end else begin
					unique case (reg_addr_i)
						dlp_pkg::OFS_COMPLETION_PENDING_REG: rdata_r <= {16'h0, completion_pending_reg_r};
						dlp_pkg::OFS_CIER: rdata_r <= {16'h0, cier_r};
						dlp_pkg::OFS_EER:  rdata_r <= {30'h0, en_r};
						dlp_pkg::OFS_STAT: rdata_r <= {28'h0, fire_w, evt_pend_r};
						default:           rdata_r <= 32'h0;
					endcase
				end
			end
		end
	end

	assign reg_rdata_o  = rdata_r;
	assign xfer_valid_o = xv_r;
	assign xfer_chan_o  = xchan_r;
	assign xfer_src_o   = xsrc_r;
	assign xfer_dst_o   = xdst_r;
	assign xfer_bytes_o = xbytes_r;
	assign irq_o        = irq_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i || !ce_i);

	chk_tx_chan_id: assert property ( // RULE1
		svc_w[0] && !svc_w[1] |=> xfer_valid_o && (xfer_chan_o == dlp_pkg::TX_CHAN_ID))
		else $error("transmit request carries wrong channel number");
	chk_rx_chan_id: assert property ( // RULE1
		svc_w[1] |=> xfer_valid_o && (xfer_chan_o == dlp_pkg::RX_CHAN_ID))
		else $error("receive request carries wrong channel number");
	chk_rx_event_served: assert property ( // RULE2
		serial_rx_event_i && en_r[1] && (opt_w[1] != 32'h0) && !(svc_w[1] && done_w[1])
		&& !reg_wr_i |-> ##[1:3] xfer_valid_o && (xfer_chan_o == dlp_pkg::RX_CHAN_ID))
		else $error("receive event not turned into an element request");
	chk_word_size: assert property ( // RULE5
		svc_w[1] && (opt_w[1][dlp_pkg::ELEMENT_SIZE_FIELD_LSB +: 2] == dlp_pkg::ESZ_32)
		|=> xfer_bytes_o == dlp_pkg::BYTES_32)
		else $error("32-bit element size not honoured");
	chk_dst_increment: assert property ( // RULE17
		svc_w[1] && !done_w[1] && !reg_wr_i
		&& (opt_w[1][dlp_pkg::DUM_LSB +: 2] == dlp_pkg::UPD_INC)
		|=> dst_w[1] == $past(dst_w[1]) + {29'h0, $past(sz_w[1])})
		else $error("destination did not step by one element");
	chk_src_fixed: assert property ( // RULE9
		svc_w[1] && !done_w[1] && !reg_wr_i
		&& (opt_w[1][dlp_pkg::SUM_LSB +: 2] == dlp_pkg::UPD_FIXED)
		|=> src_w[1] == $past(src_w[1]))
		else $error("fixed source address moved");
	chk_frame_index: assert property ( // RULE3
		svc_w[1] && le_w[1] && !done_w[1] && !reg_wr_i
		&& (opt_w[1][dlp_pkg::DUM_LSB +: 2] == dlp_pkg::UPD_IDX)
		|=> dst_w[1] == $past(dst_w[1]) + {{16{$past(idx_w[1][31])}}, $past(idx_w[1][31:16])})
		else $error("frame index not applied at frame end");
	chk_elem_reload: assert property ( // RULE8
		svc_w[1] && le_w[1] && !done_w[1] && !reg_wr_i
		|=> (cnt_w[1][15:0] == $past(rld_w[1][31:16]))
		&& (cnt_w[1][31:16] == $past(cnt_w[1][31:16]) - 16'h1))
		else $error("element count not reloaded at frame end");
	chk_link_copy: assert property ( // RULE6
		svc_w[1] && done_w[1] && opt_w[1][dlp_pkg::LINK_BIT] && !reg_wr_i
		|=> opt_w[1] == $past(lopt_w[1]))
		else $error("linked set not copied on completion");
	chk_pend_set: assert property ( // RULE13
		svc_w[1] && done_w[1] && opt_w[1][dlp_pkg::COMPLETION_IRQ_ENABLE_BIT]
		|=> completion_pending_reg_r[$past(opt_w[1][dlp_pkg::TCC_LSB +: 4])])
		else $error("completion pending bit not set");
	chk_pend_hold: assert property ( // RULE14
		completion_pending_reg_r[13] && !(reg_wr_i && (reg_addr_i == dlp_pkg::OFS_COMPLETION_PENDING_REG) && reg_wdata_i[13])
		|=> completion_pending_reg_r[13])
		else $error("pending bit dropped without a clear");
	chk_irq_follow: assert property ( // RULE12
		svc_w[1] && done_w[1] && opt_w[1][dlp_pkg::COMPLETION_IRQ_ENABLE_BIT]
		&& cier_r[opt_w[1][dlp_pkg::TCC_LSB +: 4]] && !reg_wr_i
		|=> ##1 irq_o)
		else $error("enabled completion did not interrupt");

	cov_rx_link: cover property (svc_w[1] && done_w[1] && opt_w[1][dlp_pkg::LINK_BIT]);
	cov_tx_done: cover property (svc_w[0] && done_w[0]);
	cov_both_fire: cover property (fire_w == 2'h3);
	cov_irq: cover property (irq_o);

endmodule : dlp_core

/* File: rtl/dlp_pkg.sv */
// Constants shared by the linked-reload ping-pong channel sequencer
package dlp_pkg;
	// Channel slots and their reported channel numbers
	localparam int          CH_NUM     = 2;
	localparam int          CH_TX      = 0;
	localparam int          CH_RX      = 1;
	localparam logic [3:0]  TX_CHAN_ID = 4'hc;
	localparam logic [3:0]  RX_CHAN_ID = 4'hd;

	// Parameter store layout: sets of six words, sets 0/1 are live channel sets
	localparam int          SET_WORDS  = 6;
	localparam int          SET_NUM    = 8;
	localparam int          PS_WORDS   = SET_WORDS * SET_NUM;
	localparam int          W_OPT      = 0;
	localparam int          W_SRC      = 1;
	localparam int          W_CNT      = 2;
	localparam int          W_DST      = 3;
	localparam int          W_IDX      = 4;
	localparam int          W_RLD      = 5;
	localparam logic [31:0] PS_RST     = 32'h0000_0000;

	// Options word field positions
	localparam int          ELEMENT_SIZE_FIELD_LSB  = 27;
	localparam int          SUM_LSB    = 24;
	localparam int          DUM_LSB    = 21;
	localparam int          COMPLETION_IRQ_ENABLE_BIT  = 20;
	localparam int          TCC_LSB    = 16;
	localparam int          LINK_BIT   = 1;
	localparam int          FS_BIT     = 0;

	// Address update modes and element sizes
	localparam logic [1:0]  UPD_FIXED  = 2'h0;
	localparam logic [1:0]  UPD_INC    = 2'h1;
	localparam logic [1:0]  UPD_DEC    = 2'h2;
	localparam logic [1:0]  UPD_IDX    = 2'h3;
	localparam logic [1:0]  ESZ_32     = 2'h0;
	localparam logic [1:0]  ESZ_16     = 2'h1;
	localparam logic [1:0]  ESZ_8      = 2'h2;
	localparam logic [2:0]  BYTES_32   = 3'h4;
	localparam logic [2:0]  BYTES_16   = 3'h2;
	localparam logic [2:0]  BYTES_8    = 3'h1;

	// Register port map (byte addresses)
	localparam int          AW         = 9;
	localparam logic [8:0]  OFS_PS_END = 9'h0c0;
	localparam logic [8:0]  OFS_COMPLETION_PENDING_REG   = 9'h100;
	localparam logic [8:0]  OFS_CIER   = 9'h104;
	localparam logic [8:0]  OFS_EER    = 9'h108;
	localparam logic [8:0]  OFS_STAT   = 9'h10c;
	localparam logic [15:0] COMPLETION_PENDING_REG_RST   = 16'h0000;
	localparam logic [15:0] CIER_RST   = 16'h0000;
	localparam logic [1:0]  EER_RST    = 2'h0;
endpackage : dlp_pkg

/* File: verification/dlp_serial_model.sv */
// Serial port stand-in raising one event per element on each enabled stream
`timescale 1ns/100ps
module dlp_serial_model (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       start_i,
	input  wire logic       rx_en_i,
	input  wire logic       tx_en_i,
	input  wire logic [7:0] count_i,
	input  wire logic [3:0] gap_i,
	output logic            serial_rx_event_o,
	output logic            serial_tx_event_o,
	output logic            busy_o
);
	logic [7:0] left_r;
	logic [3:0] tmr_r;

	////////////////////////////////////////////////////////////////////////////////
	// One single-cycle pulse per element, gap_i cycles apart
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			left_r <= 8'h00;
			tmr_r <= 4'h0;
			serial_rx_event_o <= 1'b0;
			serial_tx_event_o <= 1'b0;
		end else begin
			serial_rx_event_o <= 1'b0;
			serial_tx_event_o <= 1'b0;
			if (start_i) begin
				left_r <= count_i;
				tmr_r <= 4'h0;
			end else if (left_r != 8'h00) begin
				if (tmr_r == 4'h0) begin
					serial_rx_event_o <= rx_en_i;
					serial_tx_event_o <= tx_en_i;
					left_r <= left_r - 8'h01;
					tmr_r <= gap_i - 4'h1;
				end else begin
					tmr_r <= tmr_r - 4'h1;
				end
			end
		end
	end

	assign busy_o = (left_r != 8'h00);
endmodule : dlp_serial_model

/* File: verification/tb.sv */
// Self-checking bench for the linked-reload channel sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
	localparam logic [31:0] RXO = 32'h007d_0002;
	localparam logic [31:0] TXO = 32'h031c_0002;
	logic        clk_i       = 1'b0;
	logic        rst_b_i     = 1'b0;
	logic        ce_i        = 1'b1;
	logic [8:0]  reg_addr_i  = 9'h000;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	logic        start       = 1'b0;
	logic        rx_en       = 1'b0;
	logic        tx_en       = 1'b0;
	logic [7:0]  count       = 8'h00;
	logic [3:0]  gap         = 4'h1;
	logic        busy;
	logic        rx_ev;
	logic        tx_ev;
	logic [31:0] reg_rdata_o;
	logic        xfer_valid_o;
	logic [3:0]  xfer_chan_o;
	logic [31:0] xfer_src_o;
	logic [31:0] xfer_dst_o;
	logic [2:0]  xfer_bytes_o;
	logic        irq_o;
	int          fails       = 0;
	int          total_checks = 0;
	int          cyc         = 0;
	logic [66:0] rxq[$];
	logic [66:0] txq[$];

	always #4 clk_i = ~clk_i;

	dlp_core u_dlp_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
		.serial_rx_event_i(rx_ev), .serial_tx_event_i(tx_ev), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .xfer_valid_o(xfer_valid_o), .xfer_chan_o(xfer_chan_o),
		.xfer_src_o(xfer_src_o), .xfer_dst_o(xfer_dst_o), .xfer_bytes_o(xfer_bytes_o),
		.irq_o(irq_o));

	dlp_serial_model u_dlp_serial_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start),
		.rx_en_i(rx_en), .tx_en_i(tx_en), .count_i(count), .gap_i(gap),
		.serial_rx_event_o(rx_ev), .serial_tx_event_o(tx_ev), .busy_o(busy));

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [8:0] a, input logic [31:0] e, input string nm);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		`CHK(nm, e, reg_rdata_o)
	endtask : rd

	task automatic wset(input int n, input logic [31:0] o, s, c, d, x, l);
		logic [31:0] w[6];
		w = '{o, s, c, d, x, l};
		for (int k = 0; k < 6; k++) wr(9'(24 * n + 4 * k), w[k]);
	endtask : wset

	task automatic run(input logic r, t, input logic [7:0] n, input logic [3:0] g);
		int k;
		k = 0;
		@(posedge clk_i);
		rx_en <= r;
		tx_en <= t;
		count <= n;
		gap <= g;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		@(posedge clk_i);
		while (busy === 1'b1 && k < 400) begin
			@(posedge clk_i);
			k++;
		end
		repeat (8) @(posedge clk_i);
	endtask : run

	task automatic chk_q(input string nm, input logic [66:0] e, ref logic [66:0] q[$]);
		logic [66:0] g;
		g = (q.size() > 0) ? q.pop_front() : '0;
		`CHK(nm, e, g)
	endtask : chk_q

	////////////////////////////////////////////////////////////////////////////////
	// Collect every serviced element per channel
	always @(posedge clk_i) begin
		cyc++;
		if (xfer_valid_o === 1'b1) begin
			if (xfer_chan_o === dlp_pkg::RX_CHAN_ID) begin
				rxq.push_back({xfer_src_o, xfer_dst_o, xfer_bytes_o});
			end else begin
				`CHK("tx chan", dlp_pkg::TX_CHAN_ID, xfer_chan_o)
				txq.push_back({xfer_src_o, xfer_dst_o, xfer_bytes_o});
			end
		end
		if (cyc == 3000) begin
			fails++;
			report_and_stop();
		end
	end

	initial begin
		logic [31:0] dst;
		int          m;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(dlp_pkg::OFS_COMPLETION_PENDING_REG, 32'h0, "pending reset");
		rd(9'h018, 32'h0, "rx options reset");
		wr(9'h1fc, 32'hffff_ffff);
		rd(9'h1fc, 32'h0, "unmapped");
		// Ping in set 2, pong in set 3, live receive set starts as ping
		wset(2, RXO, 32'h3000_0000, 32'h0001_0002, 32'h2000, 32'h0004_0010, 32'h0002_0003);
		wset(3, RXO, 32'h3000_0000, 32'h0001_0002, 32'h4000, 32'h0004_0010, 32'h0002_0002);
		wset(1, RXO, 32'h3000_0000, 32'h0001_0002, 32'h2000, 32'h0004_0010, 32'h0002_0003);
		wset(0, TXO, 32'h8000, 32'h0000_0003, 32'h3000_0004, 32'h0000_0004, 32'h0003_0004);
		wr(dlp_pkg::OFS_CIER, 32'h0000_2000);
		wr(dlp_pkg::OFS_EER, 32'h3);
		run(1'b1, 1'b1, 8'd3, 4'd6);
		rd(dlp_pkg::OFS_COMPLETION_PENDING_REG, 32'h1000, "tx done");
		`CHK("irq masked", 1'b0, irq_o)
		rd(9'h000, 32'h0, "tx live after null");
		run(1'b1, 1'b0, 8'd5, 4'd9);
		rd(dlp_pkg::OFS_COMPLETION_PENDING_REG, 32'h3000, "rx done");
		`CHK("irq", 1'b1, irq_o)
		wr(dlp_pkg::OFS_COMPLETION_PENDING_REG, 32'h0000_2000);
		repeat (2) @(posedge clk_i);
		#1;
		`CHK("irq cleared", 1'b0, irq_o)
		rd(dlp_pkg::OFS_COMPLETION_PENDING_REG, 32'h1000, "after clear");
		wr(dlp_pkg::OFS_COMPLETION_PENDING_REG, 32'h0000_1000);
		run(1'b1, 1'b1, 8'd3, 4'd4);
		rd(dlp_pkg::OFS_COMPLETION_PENDING_REG, 32'h0, "no completion");
		rd(9'h024, 32'h0000_2024, "reloaded dst");
		rd(9'h020, 32'h0000_0001, "reloaded counts");
		// Halted receive channel takes the event but moves nothing
		wr(dlp_pkg::OFS_EER, 32'h1);
		run(1'b1, 1'b0, 8'd1, 4'd6);
		rd(dlp_pkg::OFS_STAT, 32'h0000_0003, "latched events");
		// Sixteen-bit elements, source stepping down, destination up; latched event fires first
		wset(1, 32'h0a20_0000, 32'h3000_0000, 32'h0000_0002, 32'h5000, 32'h0, 32'h0);
		wr(dlp_pkg::OFS_EER, 32'h2);
		run(1'b1, 1'b0, 8'd1, 4'd6);
		for (int i = 0; i < 11; i++) begin
			m = i % 4;
			dst = (((i / 4) % 2) == 0) ? 32'h2000 : 32'h4000;
			dst = dst + 32'(m / 2) * 32'h14 + 32'(m % 2) * 32'h10;
			chk_q("rx xfer", {32'h3000_0000, dst, dlp_pkg::BYTES_32}, rxq);
		end
		chk_q("rx inc", {32'h3000_0000, 32'h0000_5000, dlp_pkg::BYTES_16}, rxq);
		chk_q("rx dec", {32'h2fff_fffe, 32'h0000_5002, dlp_pkg::BYTES_16}, rxq);
		`CHK("rx count", 0, rxq.size())
		for (int i = 0; i < 3; i++) begin
			dst = 32'h8000 + 32'(i) * 32'h4;
			chk_q("tx xfer", {dst, 32'h3000_0004, dlp_pkg::BYTES_32}, txq);
		end
		`CHK("tx count", 0, txq.size())
		report_and_stop();
	end
endmodule : tb
